// [pkg/gpp_pkg.sv]
// Constants, register map and reset values for the two-port pin controller
// Function
// - Pin drive goes to the highest-priority enabled output function.
// - Fixed per-pin priority lists for first port, latch lowest.
// - Analog inputs stay active; digital outputs still drive by priority.
// - Port write updates latch; port read returns pin levels.
// - Port write samples pins, modifies addressed bits, stores latch.
// - Direction one tri-states the driver; zero drives the latch value.
// - First port pin three input only: direction reads one, latch zero.
// - Bits seven and six of port registers ignore writes, read zero.
// - Analog-select set forces digital reads of that pin to zero.
// - Analog-select never affects digital output driving.
// - Analog-select bits reset to analog mode.
// - First port analog-select implements bits four and two to zero.
// - Pull-up on only when enabled and global disable bit cleared.
// - Pull-up forced off whenever the pin is an output.
// - Master-clear enable turns pin three pull-up on, not reported.
// - Second port: six bits, same direction, latch, readback, analog.
// - Alternate-select bits route serial, logic cell, oscillator outputs.
// - Latch register read returns latch contents, not pin levels.
package gpp_pkg;
	localparam int PORT_W = 6;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	// Register byte offsets
	localparam logic [7:0] OFS_FIRST_LEVELS = 8'h00;
	localparam logic [7:0] OFS_FIRST_DIR = 8'h04;
	localparam logic [7:0] OFS_FIRST_LATCH = 8'h08;
	localparam logic [7:0] OFS_FIRST_ANALOG = 8'h0c;
	localparam logic [7:0] OFS_FIRST_PULLUP = 8'h10;
	localparam logic [7:0] OFS_SECOND_LEVELS = 8'h14;
	localparam logic [7:0] OFS_SECOND_DIR = 8'h18;
	localparam logic [7:0] OFS_SECOND_LATCH = 8'h1c;
	localparam logic [7:0] OFS_SECOND_ANALOG = 8'h20;
	localparam logic [7:0] OFS_SECOND_PULLUP = 8'h24;
	localparam logic [7:0] OFS_ALT_SEL = 8'h28;
	localparam logic [7:0] OFS_CTRL = 8'h2c;
	// Implemented-bit masks
	localparam logic [5:0] PORT_MASK = 6'h3f;
	localparam logic [5:0] FIRST_IMPL_MASK = 6'h37;
	localparam logic [5:0] FIRST_ANALOG_MASK = 6'h17;
	localparam logic [5:0] SECOND_ANALOG_MASK = 6'h0f;
	localparam logic [5:0] ALT_MASK = 6'h3b;
	localparam logic [5:0] PIN3_BIT = 6'h08;
	// Field positions
	localparam int INPUT_ONLY_PIN = 3;
	localparam int SERIAL_OUT_PIN_SEL_BIT = 5;
	localparam int LOGIC_CELL_PIN_SEL_BIT = 1;
	localparam int OSCILLATOR_PIN_SEL_BIT = 0;
	localparam int CTRL_PULLUP_DIS_BIT = 0;
	localparam int CTRL_MCLR_BIT = 1;
	localparam int RMW_SEL_LSB = 8;
	// Reset values
	localparam logic [5:0] RST_DIR = 6'h3f;
	localparam logic [5:0] RST_LATCH = 6'h00;
	localparam logic [5:0] RST_FIRST_ANALOG = 6'h17;
	localparam logic [5:0] RST_SECOND_ANALOG = 6'h0f;
	localparam logic [5:0] RST_PULLUP = 6'h3f;
	localparam logic [5:0] RST_ALT = 6'h00;
	localparam logic [1:0] RST_CTRL = 2'h1;
endpackage : gpp_pkg

// [hw/gpp_pin_sync.sv]
// Three-stage pin input synchroniser with agreement filter
`timescale 1ns/1ps
module gpp_pin_sync #(
	parameter int WIDTH = 6
) (
	// Clock and reset
	input logic pclk,
	input logic presetn,
	// Asynchronous pins in, settled levels out
	input logic [WIDTH-1:0] pin_async,
	output logic [WIDTH-1:0] pin_level
);
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++)
		begin : g_bit
			logic stage1_ff;
			logic stage2_ff;
			logic stage3_ff;
			logic level_ff;
			// First stage feeds only the second, to keep metastability contained
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					stage1_ff <= 1'b0;
					stage2_ff <= 1'b0;
					stage3_ff <= 1'b0;
				end
				else
				begin
					stage1_ff <= pin_async[i];
					stage2_ff <= stage1_ff;
					stage3_ff <= stage2_ff;
				end
			end
			// Level moves only when the two later stages agree
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
					level_ff <= 1'b0;
				else if (stage2_ff == stage3_ff)
					level_ff <= stage3_ff;
			end
			assign pin_level[i] = level_ff;
		end
	endgenerate
endmodule : gpp_pin_sync

// [hw/gpp_port_pair.sv]
// Two six-bit general purpose ports with APB registers and output priority
`timescale 1ns/1ps
module gpp_port_pair (
	// Clock and reset
	input logic pclk,
	input logic presetn,
	// APB slave
	input logic psel,
	input logic penable,
	input logic pwrite,
	input logic [gpp_pkg::ADDR_W-1:0] paddr,
	input logic [gpp_pkg::DATA_W-1:0] pwdata,
	output logic [gpp_pkg::DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	// First port pins
	input logic [gpp_pkg::PORT_W-1:0] first_pin_in,
	output logic [gpp_pkg::PORT_W-1:0] first_pin_out,
	output logic [gpp_pkg::PORT_W-1:0] first_pin_oe,
	output logic [gpp_pkg::PORT_W-1:0] first_pin_pullup,
	output logic [gpp_pkg::PORT_W-1:0] first_pin_digital,
	// Second port pins
	input logic [gpp_pkg::PORT_W-1:0] second_pin_in,
	output logic [gpp_pkg::PORT_W-1:0] second_pin_out,
	output logic [gpp_pkg::PORT_W-1:0] second_pin_oe,
	output logic [gpp_pkg::PORT_W-1:0] second_pin_pullup,
	output logic [gpp_pkg::PORT_W-1:0] second_pin_digital,
	// Peripheral output functions, each with its enable
	input logic programming_data_out_en,
	input logic programming_data_out,
	input logic dac_output_one_en,
	input logic dac_output_one,
	input logic dac_output_two_en,
	input logic dac_output_two,
	input logic logic_cell_one_out_en,
	input logic logic_cell_one_out,
	input logic comparator_one_out_en,
	input logic comparator_one_out,
	input logic pwm_channel_three_en,
	input logic pwm_channel_three,
	input logic clock_output_en,
	input logic clock_output,
	input logic numeric_oscillator_out_en,
	input logic numeric_oscillator_out,
	input logic serial_data_out_en,
	input logic serial_data_out
);
	import gpp_pkg::*;

	logic [5:0] first_dir_ff;
	logic [5:0] first_latch_ff;
	logic [5:0] first_analog_sel_ff;
	logic [5:0] first_pullup_en_ff;
	logic [5:0] second_dir_ff;
	logic [5:0] second_latch_ff;
	logic [5:0] second_analog_sel_ff;
	logic [5:0] second_pullup_en_ff;
	logic [5:0] alt_pin_select_ff;
	logic global_pullup_disable_n_ff;
	logic master_clear_pin_enable_ff;
	logic [DATA_W-1:0] prdata_ff;
	logic [5:0] first_pin_out_ff;
	logic [5:0] second_pin_out_ff;
	logic [5:0] nxt_first_pin_out;
	logic [5:0] nxt_second_pin_out;
	logic [5:0] first_sync;
	logic [5:0] second_sync;
	logic [5:0] first_levels;
	logic [5:0] second_levels;
	logic [5:0] rmw_sel;
	logic wr_en;
	logic rd_setup;
	logic serial_out_pin_sel;
	logic logic_cell_pin_sel;
	logic oscillator_pin_sel;

	// Address decode for the error answer; read data decodes in its own case
	function automatic logic gpp_mapped(input logic [ADDR_W-1:0] addr);
		logic hit;
		hit = 1'b0;
		case (addr)
			OFS_FIRST_LEVELS, OFS_FIRST_DIR, OFS_FIRST_LATCH, OFS_FIRST_ANALOG, OFS_FIRST_PULLUP,
			OFS_SECOND_LEVELS, OFS_SECOND_DIR, OFS_SECOND_LATCH, OFS_SECOND_ANALOG, OFS_SECOND_PULLUP,
			OFS_ALT_SEL, OFS_CTRL: hit = 1'b1;
			default: hit = 1'b0;
		endcase
		return hit;
	endfunction : gpp_mapped

	// Pull-up gating used for both ports
	function automatic logic [5:0] gpp_pullup(input logic [5:0] en, input logic [5:0] dir, input logic dis);
		logic [5:0] res;
		res = dis ? 6'h00 : (en & dir);
		return res;
	endfunction : gpp_pullup

	// Pin synchronisers for both ports
	gpp_pin_sync #(
		.WIDTH(PORT_W)
	) u_first_sync (
		.pclk(pclk),
		.presetn(presetn),
		.pin_async(first_pin_in),
		.pin_level(first_sync)
	);

	gpp_pin_sync #(
		.WIDTH(PORT_W)
	) u_second_sync (
		.pclk(pclk),
		.presetn(presetn),
		.pin_async(second_pin_in),
		.pin_level(second_sync)
	);

	// Analog pins read zero; peripherals see the same gated levels
	assign first_levels = first_sync & ~first_analog_sel_ff;
	assign second_levels = second_sync & ~second_analog_sel_ff;
	assign first_pin_digital = first_levels;
	assign second_pin_digital = second_levels;

	// APB strobes; the slave never stretches a transfer
	assign wr_en = psel & penable & pwrite;
	assign rd_setup = psel & ~penable & ~pwrite;
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~gpp_mapped(paddr);
	assign prdata = prdata_ff;

	// Bits to modify on a port write; an empty select means the whole port
	assign rmw_sel = (pwdata[RMW_SEL_LSB +: PORT_W] == 6'h00) ? PORT_MASK : pwdata[RMW_SEL_LSB +: PORT_W];

	assign serial_out_pin_sel = alt_pin_select_ff[SERIAL_OUT_PIN_SEL_BIT];
	assign logic_cell_pin_sel = alt_pin_select_ff[LOGIC_CELL_PIN_SEL_BIT];
	assign oscillator_pin_sel = alt_pin_select_ff[OSCILLATOR_PIN_SEL_BIT];

	// Read data captured in the setup cycle, stable through the access phase
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata_ff <= 32'h0000_0000;
		else if (rd_setup)
		begin
			case (paddr)
				OFS_FIRST_LEVELS: prdata_ff <= {26'h0, first_levels};
				OFS_FIRST_DIR: prdata_ff <= {26'h0, first_dir_ff | PIN3_BIT};
				OFS_FIRST_LATCH: prdata_ff <= {26'h0, first_latch_ff};
				OFS_FIRST_ANALOG: prdata_ff <= {26'h0, first_analog_sel_ff};
				OFS_FIRST_PULLUP: prdata_ff <= {26'h0, first_pullup_en_ff};
				OFS_SECOND_LEVELS: prdata_ff <= {26'h0, second_levels};
				OFS_SECOND_DIR: prdata_ff <= {26'h0, second_dir_ff};
				OFS_SECOND_LATCH: prdata_ff <= {26'h0, second_latch_ff};
				OFS_SECOND_ANALOG: prdata_ff <= {26'h0, second_analog_sel_ff};
				OFS_SECOND_PULLUP: prdata_ff <= {26'h0, second_pullup_en_ff};
				OFS_ALT_SEL: prdata_ff <= {26'h0, alt_pin_select_ff};
				OFS_CTRL: prdata_ff <= {30'h0, master_clear_pin_enable_ff, global_pullup_disable_n_ff};
				default: prdata_ff <= 32'h0000_0000;
			endcase
		end
	end

	// First port latch: port write is read-modify-write of the pin levels
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			first_latch_ff <= RST_LATCH;
		else if (wr_en && paddr == OFS_FIRST_LEVELS)
			first_latch_ff <= ((first_levels & ~rmw_sel) | (pwdata[5:0] & rmw_sel)) & FIRST_IMPL_MASK;
		else if (wr_en && paddr == OFS_FIRST_LATCH)
			first_latch_ff <= pwdata[5:0] & FIRST_IMPL_MASK;
	end

	// Second port latch, same scheme
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			second_latch_ff <= RST_LATCH;
		else if (wr_en && paddr == OFS_SECOND_LEVELS)
			second_latch_ff <= (second_levels & ~rmw_sel) | (pwdata[5:0] & rmw_sel);
		else if (wr_en && paddr == OFS_SECOND_LATCH)
			second_latch_ff <= pwdata[5:0];
	end

	// Direction registers; pin three of the first port stays input
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			first_dir_ff <= RST_DIR;
			second_dir_ff <= RST_DIR;
		end
		else
		begin
			if (wr_en && paddr == OFS_FIRST_DIR)
				first_dir_ff <= (pwdata[5:0] & FIRST_IMPL_MASK) | PIN3_BIT;
			if (wr_en && paddr == OFS_SECOND_DIR)
				second_dir_ff <= pwdata[5:0];
		end
	end

	// Analog select, resetting to analog mode
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			first_analog_sel_ff <= RST_FIRST_ANALOG;
			second_analog_sel_ff <= RST_SECOND_ANALOG;
		end
		else
		begin
			if (wr_en && paddr == OFS_FIRST_ANALOG)
				first_analog_sel_ff <= pwdata[5:0] & FIRST_ANALOG_MASK;
			if (wr_en && paddr == OFS_SECOND_ANALOG)
				second_analog_sel_ff <= pwdata[5:0] & SECOND_ANALOG_MASK;
		end
	end

	// Pull-up enables, alternate routing and control bits
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			first_pullup_en_ff <= RST_PULLUP;
			second_pullup_en_ff <= RST_PULLUP;
			alt_pin_select_ff <= RST_ALT;
			global_pullup_disable_n_ff <= RST_CTRL[CTRL_PULLUP_DIS_BIT];
			master_clear_pin_enable_ff <= RST_CTRL[CTRL_MCLR_BIT];
		end
		else
		begin
			if (wr_en && paddr == OFS_FIRST_PULLUP)
				first_pullup_en_ff <= pwdata[5:0];
			if (wr_en && paddr == OFS_SECOND_PULLUP)
				second_pullup_en_ff <= pwdata[5:0];
			if (wr_en && paddr == OFS_ALT_SEL)
				alt_pin_select_ff <= pwdata[5:0] & ALT_MASK;
			if (wr_en && paddr == OFS_CTRL)
			begin
				global_pullup_disable_n_ff <= pwdata[CTRL_PULLUP_DIS_BIT];
				master_clear_pin_enable_ff <= pwdata[CTRL_MCLR_BIT];
			end
		end
	end

	// First port output priority, highest first; latch is the fallback
	always_comb
	begin
		nxt_first_pin_out = first_latch_ff;
		if (programming_data_out_en)
			nxt_first_pin_out[0] = programming_data_out;
		else if (dac_output_one_en)
			nxt_first_pin_out[0] = dac_output_one;
		if (dac_output_two_en)
			nxt_first_pin_out[2] = dac_output_two;
		else if (logic_cell_one_out_en && !logic_cell_pin_sel)
			nxt_first_pin_out[2] = logic_cell_one_out;
		else if (comparator_one_out_en)
			nxt_first_pin_out[2] = comparator_one_out;
		else if (pwm_channel_three_en)
			nxt_first_pin_out[2] = pwm_channel_three;
		nxt_first_pin_out[INPUT_ONLY_PIN] = 1'b0;
		if (clock_output_en)
			nxt_first_pin_out[4] = clock_output;
		else if (numeric_oscillator_out_en && oscillator_pin_sel)
			nxt_first_pin_out[4] = numeric_oscillator_out;
		else if (serial_data_out_en && serial_out_pin_sel)
			nxt_first_pin_out[4] = serial_data_out;
	end

	// Second port: routed functions override the latch on their pins
	always_comb
	begin
		nxt_second_pin_out = second_latch_ff;
		if (numeric_oscillator_out_en && !oscillator_pin_sel)
			nxt_second_pin_out[1] = numeric_oscillator_out;
		if (serial_data_out_en && !serial_out_pin_sel)
			nxt_second_pin_out[2] = serial_data_out;
		if (logic_cell_one_out_en && logic_cell_pin_sel)
			nxt_second_pin_out[5] = logic_cell_one_out;
	end

	// Registered pin values keep the pads glitch free, at one cycle of latency
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			first_pin_out_ff <= 6'h00;
			second_pin_out_ff <= 6'h00;
		end
		else
		begin
			first_pin_out_ff <= nxt_first_pin_out;
			second_pin_out_ff <= nxt_second_pin_out;
		end
	end
	assign first_pin_out = first_pin_out_ff;
	assign second_pin_out = second_pin_out_ff;

	// Drivers follow direction only; analog select does not gate them
	assign first_pin_oe = ~first_dir_ff & ~PIN3_BIT;
	assign second_pin_oe = ~second_dir_ff;

	// Weak pull-ups; pin three also pulled up internally for master clear
	assign first_pin_pullup = gpp_pullup(first_pullup_en_ff, first_dir_ff, global_pullup_disable_n_ff)
		| (master_clear_pin_enable_ff ? PIN3_BIT : 6'h00);
	assign second_pin_pullup = gpp_pullup(second_pullup_en_ff, second_dir_ff, global_pullup_disable_n_ff);

	// Checks
	sequence s_first_latch_write;
		psel && penable && pwrite && paddr == OFS_FIRST_LATCH;
	endsequence

	sequence s_first_port_write;
		psel && penable && pwrite && paddr == OFS_FIRST_LEVELS;
	endsequence

	a_prog_priority: assert property (@(posedge pclk) disable iff (!presetn)
		programming_data_out_en |=> first_pin_out[0] == $past(programming_data_out))
		else $error("pin0 not driven by programming data");

	a_pin2_dac_wins: assert property (@(posedge pclk) disable iff (!presetn)
		dac_output_two_en && pwm_channel_three_en |=> first_pin_out[2] == $past(dac_output_two))
		else $error("pin2 priority wrong");

	a_osc_route_pin4: assert property (@(posedge pclk) disable iff (!presetn)
		!clock_output_en && numeric_oscillator_out_en && oscillator_pin_sel
		|=> first_pin_out[4] == $past(numeric_oscillator_out) && second_pin_out[1] == $past(second_latch_ff[1]))
		else $error("oscillator routing wrong");

	a_pin3_input_only: assert property (@(posedge pclk) disable iff (!presetn)
		!first_pin_oe[3] && first_dir_ff[3])
		else $error("pin3 driven or direction cleared");

	a_oe_from_dir: assert property (@(posedge pclk) disable iff (!presetn)
		(second_pin_oe == ~second_dir_ff) && ((first_pin_oe | first_dir_ff) == PORT_MASK))
		else $error("output enable does not follow direction");

	a_latch_write_store: assert property (@(posedge pclk) disable iff (!presetn)
		s_first_latch_write |=> first_latch_ff == ($past(pwdata[5:0]) & FIRST_IMPL_MASK))
		else $error("latch write not stored");

	a_rmw_port_write: assert property (@(posedge pclk) disable iff (!presetn)
		s_first_port_write |=> first_latch_ff ==
		((($past(first_levels) & ~$past(rmw_sel)) | ($past(pwdata[5:0]) & $past(rmw_sel))) & FIRST_IMPL_MASK))
		else $error("port write not read-modify-write");

	a_analog_reads_zero: assert property (@(posedge pclk) disable iff (!presetn)
		psel && penable && !pwrite && paddr == OFS_FIRST_LEVELS |-> (prdata[5:0] & first_analog_sel_ff) == 6'h00)
		else $error("analog pin read nonzero");

	a_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
		psel && penable && !pwrite |-> prdata[31:6] == 26'h0)
		else $error("reserved bits nonzero");

	a_pullup_off_out: assert property (@(posedge pclk) disable iff (!presetn)
		(second_pin_pullup & ~second_dir_ff) == 6'h00 && (first_pin_pullup & ~first_dir_ff) == 6'h00)
		else $error("pull-up on an output pin");

	a_mclr_pullup: assert property (@(posedge pclk) disable iff (!presetn)
		master_clear_pin_enable_ff |-> first_pin_pullup[3])
		else $error("pin3 pull-up missing");

endmodule : gpp_port_pair

// [test/gpp_pin_model.sv]
// Pad-side partner: resolves each pad from device driver, board source and pull-up
`timescale 1ns/1ps
module gpp_pin_model (
	// Clock
	input wire logic pclk,
	// Device side of the pads
	input wire logic [5:0] pin_out,
	input wire logic [5:0] pin_oe,
	input wire logic [5:0] pin_pullup,
	// Board source
	input wire logic [5:0] ext_en,
	input wire logic [5:0] ext_val,
	// Resolved pad levels
	output logic [5:0] pin_level
);
	logic [5:0] float_ff = 6'h2a;
	// Floating pads wander so a stale level never passes for a read
	always_ff @(posedge pclk)
	begin
		float_ff <= ~float_ff;
	end
	// Device driver wins, then the board, then the weak pull-up
	always_comb
	begin
		pin_level = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val) | (~pin_oe & ~ext_en & pin_pullup)
			| (~pin_oe & ~ext_en & ~pin_pullup & float_ff);
	end
endmodule : gpp_pin_model

// [test/tb_top.sv]
// Self-checking bench for the two-port pin controller
`timescale 1ns/1ps
module tb_top;
	import gpp_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata;
	logic [5:0] f_in, f_out, f_oe, f_pu, f_dig, s_in, s_out, s_oe, s_pu, s_dig;
	logic [5:0] ext1 = 6'h2d, ext2 = 6'h13;
	logic [17:0] pv = 18'h0;
	logic [11:0] o;
	int seed = 32'h72838e38;
	int errors = 0, n_compared = 0, i, k;
	// Register model, indexed by byte offset over four
	int m_rst [0:11] = '{0, 'h37, 0, 'h17, 'h3f, 0, 'h3f, 0, 'h0f, 'h3f, 0, 1};
	int m [0:11];
	int wmask [0:11] = '{0, 'h37, 'h37, 'h17, 'h3f, 0, 'h3f, 'h3f, 'h0f, 'h3f, 'h3b, 'h3};

	always #5 pclk = ~pclk;

	gpp_port_pair u_gpp_port_pair (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.first_pin_in(f_in), .first_pin_out(f_out), .first_pin_oe(f_oe), .first_pin_pullup(f_pu),
		.first_pin_digital(f_dig), .second_pin_in(s_in), .second_pin_out(s_out), .second_pin_oe(s_oe),
		.second_pin_pullup(s_pu), .second_pin_digital(s_dig),
		.programming_data_out_en(pv[0]), .programming_data_out(pv[1]), .dac_output_one_en(pv[2]),
		.dac_output_one(pv[3]), .dac_output_two_en(pv[4]), .dac_output_two(pv[5]),
		.logic_cell_one_out_en(pv[6]), .logic_cell_one_out(pv[7]), .comparator_one_out_en(pv[8]),
		.comparator_one_out(pv[9]), .pwm_channel_three_en(pv[10]), .pwm_channel_three(pv[11]),
		.clock_output_en(pv[12]), .clock_output(pv[13]), .numeric_oscillator_out_en(pv[14]),
		.numeric_oscillator_out(pv[15]), .serial_data_out_en(pv[16]), .serial_data_out(pv[17]));
	gpp_pin_model u_pins_first (.pclk(pclk), .pin_out(f_out), .pin_oe(f_oe), .pin_pullup(f_pu),
		.ext_en(6'h3f), .ext_val(ext1), .pin_level(f_in));
	gpp_pin_model u_pins_second (.pclk(pclk), .pin_out(s_out), .pin_oe(s_oe), .pin_pullup(s_pu),
		.ext_en(6'h3f), .ext_val(ext2), .pin_level(s_in));

	// Expected pad values: later assignments carry higher priority
	function automatic logic [11:0] exp_out();
		logic [5:0] a, b;
		a = m[2][5:0];
		b = m[7][5:0];
		if (pv[2]) a[0] = pv[3];
		if (pv[0]) a[0] = pv[1];
		if (pv[10]) a[2] = pv[11];
		if (pv[8]) a[2] = pv[9];
		if (pv[6] && !m[10][1]) a[2] = pv[7];
		if (pv[4]) a[2] = pv[5];
		if (pv[16] && m[10][5]) a[4] = pv[17];
		if (pv[14] && m[10][0]) a[4] = pv[15];
		if (pv[12]) a[4] = pv[13];
		if (pv[14] && !m[10][0]) b[1] = pv[15];
		if (pv[16] && !m[10][5]) b[2] = pv[17];
		if (pv[6] && m[10][1]) b[5] = pv[7];
		return {b, a};
	endfunction : exp_out

	// Pad levels as the bench expects them
	function automatic logic [5:0] lvl(input int p);
		logic [11:0] x;
		logic [5:0] oe;
		x = exp_out();
		oe = p ? 6'(~m[6][5:0]) : 6'(~m[1][5:0] & 6'h37);
		return p ? (oe & x[11:6]) | (~oe & ext2) : (oe & x[5:0]) | (~oe & ext1);
	endfunction : lvl

	function automatic logic [31:0] exp_rd(input int r);
		case (r)
			0: return 32'(lvl(0) & 6'(~m[3][5:0]));
			1: return m[1] | 8;
			5: return 32'(lvl(1) & 6'(~m[8][5:0]));
			default: return m[r];
		endcase
	endfunction : exp_rd

	task automatic cmp(input logic [31:0] g, input logic [31:0] x);
		n_compared++;
		if (g !== x)
		begin
			errors++;
			$display("ERROR %0t got %h expected %h", $time, g, x);
		end
	endtask : cmp

	// One APB transfer; request held until ready is seen
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
		output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// No assumed wait count; only the watchdog ends a hung access
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		cmp({31'h0, pready}, 32'h1);
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		logic [5:0] sel, lv;
		int x;
		x = a >> 2;
		sel = (d[13:8] == 6'h0) ? 6'h3f : d[13:8];
		lv = lvl(x == 5) & 6'(~m[x == 5 ? 8 : 3][5:0]);
		apb(1'b1, a, d, r, e);
		if (x == 0 || x == 5)
			m[x + 2] = ((lv & ~sel) | (d[5:0] & sel)) & wmask[x + 2];
		else
			m[x] = d & wmask[x];
	endtask : wr

	task automatic rd(input int x);
		logic [31:0] r;
		logic e;
		apb(1'b0, 8'(x * 4), 32'h0, r, e);
		cmp(r, exp_rd(x));
		cmp({31'h0, e}, 32'h0);
	endtask : rd

	task automatic report_and_stop();
		$display("errors %0d compared %0d", errors, n_compared);
		if (errors == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : report_and_stop

	// Watchdog against a hung handshake
	initial
	begin
		#200000;
		errors++;
		report_and_stop();
	end

	// Reset values first, then random configurations with peripherals and pads
	initial
	begin
		logic [31:0] r;
		logic e;
		logic [31:0] d;
		m = m_rst;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		for (k = 0; k < 30; k++)
		begin
			if (k == 15)
			begin
				// Second reset mid-run; every register must fall back to its reset value
				@(posedge pclk);
				presetn <= 1'b0;
				repeat (2) @(posedge pclk);
				presetn <= 1'b1;
				m = m_rst;
			end
			else if (k > 0)
			begin
				@(posedge pclk);
				pv <= 18'($random(seed));
				ext1 <= 6'($random(seed));
				ext2 <= 6'($random(seed));
				for (i = 1; i < 12; i++)
					if (i != 5)
					begin
						d = $random(seed);
						// Some rounds keep analog pins as inputs, others test driving analog pins
						if ((i == 3 || i == 8) && k % 3 == 0)
							d = d & m[i - 2];
						wr(8'(i * 4), d);
					end
				repeat (10) @(posedge pclk);
				wr((k % 2) ? OFS_SECOND_LEVELS : OFS_FIRST_LEVELS, $random(seed));
			end
			repeat (10) @(posedge pclk);
			o = exp_out();
			cmp(f_out & 6'h37, o[5:0] & 6'h37);
			cmp(s_out, o[11:6]);
			cmp(f_oe, 6'(~m[1][5:0] & 6'h37));
			cmp(s_oe, 6'(~m[6][5:0]));
			cmp(f_pu, (m[4][5:0] & (m[1][5:0] | 6'h08) & {6{~m[11][0]}}) | {2'b0, m[11][1], 3'b0});
			cmp(s_pu, m[9][5:0] & m[6][5:0] & {6{~m[11][0]}});
			cmp(f_dig, lvl(0) & 6'(~m[3][5:0]));
			cmp(s_dig, lvl(1) & 6'(~m[8][5:0]));
			for (i = 0; i < 12; i++)
				rd(i);
		end
		// Unmapped place answers with an error and zero data
		apb(1'b0, 8'h30, 32'h0, r, e);
		cmp(r, 32'h0);
		cmp({31'h0, e}, 32'h1);
		report_and_stop();
	end
endmodule : tb_top
